// >>> hw/ptmc_edge_detect.sv
// level capture and edge detection of the external trigger
`timescale 1ns/1ps
`default_nettype none

module ptmc_edge_detect
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sig_in,
  input wire logic freeze,
  ptmc_edge_if.src edge_bus
);
  import ptmc_pkg::*;

  logic level_q;
  logic level_d;

  // frozen level makes the trigger invisible: no edge, no level change
  assign level_d = freeze ? level_q : sig_in;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      level_q <= 1'b0;
    else
      level_q <= level_d;
  end

  assign edge_bus.level = level_q;
  assign edge_bus.rise = level_d & ~level_q;
  assign edge_bus.fall = ~level_d & level_q;

endmodule : ptmc_edge_detect

`default_nettype wire

// >>> hw/ptmc_timer.sv
// mode control and counter of the 8-bit period timer
//
// Overview of operation
// - five-bit mode, class in [4:3], variant in [2:0]; class 11 and some codes reserved
// - in debug mode all trigger activity is ignored
// - free 000 counts while enable is set, trigger unused
// - free 001/010 count only with enable and trigger high/low
// - free 011/100/101 run on enable, clear count on any/rising/falling edge
// - free 110/111 held reset while trigger low/high, count once released
// - one-shot 000 starts on enable, clearing enable stops it
// - one-shot: clock after period match clears enable, count stops at zero
// - one-shot 001/010/011 start on rising/falling/any edge after enable
// - edge-started modes need a fresh edge after enable is set again
// - one-shot 100-111 start on edge, then reset on edge or level
// - monostable edge modes restart on later edges; match keeps enable set
// - count increments each clock while running, clears to zero after period match
// - every external reset also sets scaler_clear_q on the next clock
`timescale 1ns/1ps
`default_nettype none
`include "ptmc_defs.svh"

module ptmc_timer
#(
  parameter int COUNT_W = `PTMC_COUNT_W
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [`PTMC_MODE_W-1:0] mode,
  input wire logic [COUNT_W-1:0] timer_period,
  input wire logic enable_set,
  input wire logic enable_clear,
  input wire logic ext_trigger_signal,
  input wire logic debug_mode,
  output logic [COUNT_W-1:0] timer_count_q,
  output logic enable_q,
  output logic running_q,
  output logic period_match_q,
  output logic scaler_clear_q,
  output logic mode_reserved_q
);
  import ptmc_pkg::*;

  // ----------------------------------------
  // trigger detection
  // ----------------------------------------
  ptmc_edge_if trig ();

  ptmc_edge_detect u_edge (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sig_in(ext_trigger_signal),
    .freeze(debug_mode),
    .edge_bus(trig)
  );

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  ptmc_class_type cls;
  ptmc_variant_type vnt;
  wire is_free;
  wire is_os;
  wire is_ms;
  wire reserved;
  wire lvl;
  wire rise_on;
  wire fall_on;
  wire any_on;

  assign cls = ptmc_class_type'(mode[`PTMC_CLS_HI:`PTMC_CLS_LO]);
  assign vnt = mode[`PTMC_VAR_HI:`PTMC_VAR_LO];
  assign is_free = (cls == PTMC_FREE);
  assign is_os = (cls == PTMC_ONESHOT);
  assign is_ms = (cls == PTMC_MONO);
  assign reserved = (cls == PTMC_RSVD) |
                    (is_ms & ((vnt == `PTMC_V0) | (vnt == `PTMC_V4) | (vnt == `PTMC_V5)));
  assign lvl = trig.level;
  assign rise_on = trig.rise;
  assign fall_on = trig.fall;
  assign any_on = trig.rise | trig.fall;

  // start edge per variant; edge spacing at the source keeps these clean
  wire ms_edge_mode;
  wire ms_level_mode;
  wire edge_start_mode;
  wire start_edge;

  assign ms_edge_mode = is_ms & ((vnt == `PTMC_V1) | (vnt == `PTMC_V2) | (vnt == `PTMC_V3));
  assign ms_level_mode = is_ms & ((vnt == `PTMC_V6) | (vnt == `PTMC_V7));
  assign edge_start_mode = (is_os & (vnt != `PTMC_V0)) | ms_edge_mode;
  assign start_edge = ((vnt == `PTMC_V1) | (vnt == `PTMC_V4) | (vnt == `PTMC_V6)) ? rise_on :
                      ((vnt == `PTMC_V2) | (vnt == `PTMC_V5) | (vnt == `PTMC_V7)) ? fall_on :
                      (vnt == `PTMC_V3) ? any_on : 1'b0;

  // ----------------------------------------
  // run and reset conditions
  // ----------------------------------------
  logic armed_q;
  logic armed_d;
  wire free_run;
  wire level_run;
  wire run;
  wire ext_reset;

  assign free_run = (vnt == `PTMC_V1) ? lvl :
                    (vnt == `PTMC_V2) ? ~lvl :
                    (vnt == `PTMC_V6) ? lvl :
                    (vnt == `PTMC_V7) ? ~lvl : 1'b1;

  // level-start monostable: six-clock level minimum assumed at the source
  assign level_run = (vnt == `PTMC_V6) ? lvl : ~lvl;

  assign run = enable_q & ~reserved &
               (is_free ? free_run :
                edge_start_mode ? armed_q :
                ms_level_mode ? level_run :
                is_os);

  // resets only act while enabled; a hold in reset also stops counting
  assign ext_reset = enable_q & ~reserved &
                     ((is_free & (vnt == `PTMC_V3) & any_on) |
                      (is_free & (vnt == `PTMC_V4) & rise_on) |
                      (is_free & (vnt == `PTMC_V5) & fall_on) |
                      (is_free & (vnt == `PTMC_V6) & ~lvl) |
                      (is_free & (vnt == `PTMC_V7) & lvl) |
                      (is_os & armed_q & (vnt == `PTMC_V4) & rise_on) |
                      (is_os & armed_q & (vnt == `PTMC_V5) & fall_on) |
                      (is_os & armed_q & (vnt == `PTMC_V6) & ~lvl) |
                      (is_os & armed_q & (vnt == `PTMC_V7) & lvl) |
                      (ms_level_mode & ~level_run));

  // ----------------------------------------
  // count, match and enable
  // ----------------------------------------
  logic [COUNT_W-1:0] count_d;
  logic enable_d;
  wire match;
  wire stop_clear_en;

  assign match = run & (timer_count_q == timer_period);
  assign stop_clear_en = match & (is_os | ms_level_mode);

  assign count_d = ext_reset ? COUNT_W'(`PTMC_COUNT_RST) :
                   match ? COUNT_W'(`PTMC_COUNT_RST) :
                   run ? timer_count_q + COUNT_W'(1) :
                   timer_count_q;

  // software set wins over the hardware clear in the same clock
  assign enable_d = enable_set ? 1'b1 : (enable_clear | stop_clear_en) ? 1'b0 : enable_q;

  // arm survives resets; lost on disable or on a monostable match
  assign armed_d = enable_q & ~enable_clear & ~stop_clear_en &
                   ~(ms_edge_mode & match) &
                   (armed_q | (edge_start_mode & start_edge));

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      timer_count_q <= COUNT_W'(`PTMC_COUNT_RST);
      enable_q <= 1'b0;
      armed_q <= 1'b0;
      running_q <= 1'b0;
      period_match_q <= 1'b0;
      scaler_clear_q <= 1'b0;
      mode_reserved_q <= 1'b0;
    end
    else
    begin
      timer_count_q <= count_d;
      enable_q <= enable_d;
      armed_q <= armed_d;
      running_q <= run;
      period_match_q <= match;
      scaler_clear_q <= ext_reset;
      mode_reserved_q <= reserved;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_match_clears_count: assert property (match && !ext_reset |=> timer_count_q == '0)
    else $error("count not zero after period match");
  a_count_increments: assert property (run && !match && !ext_reset |=> timer_count_q == $past(timer_count_q) + 1'b1)
    else $error("count failed to increment");
  a_oneshot_clear_en: assert property (match && is_os && !enable_set |=> !enable_q && timer_count_q == '0)
    else $error("one-shot match did not clear enable");
  a_mono_keeps_en: assert property (match && ms_edge_mode && !enable_clear |=> enable_q && !armed_q)
    else $error("monostable match changed enable or kept running");
  a_debug_no_edge: assert property (debug_mode |-> !trig.rise && !trig.fall)
    else $error("trigger edge seen in debug mode");
  a_soft_gate_run: assert property (is_free && vnt == `PTMC_V0 |-> run == enable_q)
    else $error("software gate run differs from enable");
  a_hw_gate_high: assert property (is_free && vnt == `PTMC_V1 && enable_q && !lvl |-> !run)
    else $error("hardware gate ran with trigger low");
  a_level_hold: assert property (is_free && vnt == `PTMC_V6 && enable_q && !lvl |=> timer_count_q == '0)
    else $error("count not held reset on low level");
  a_edge_reset_free: assert property (is_free && vnt == `PTMC_V4 && enable_q && rise_on |=> timer_count_q == '0)
    else $error("rising edge did not clear count");
  a_fresh_edge: assert property (edge_start_mode && !enable_q |=> !armed_q)
    else $error("armed survived disable");
  a_edge_start_wait: assert property (is_os && vnt == `PTMC_V1 && !armed_q |-> !run)
    else $error("edge one-shot ran without start edge");
  a_reserved_idle: assert property (reserved |-> !run && !ext_reset)
    else $error("reserved mode active");
  a_scaler_clear: assert property (ext_reset |=> scaler_clear_q)
    else $error("scaler clear missing after external reset");
  a_level_mono: assert property (ms_level_mode && enable_q && vnt == `PTMC_V6 |-> run == lvl)
    else $error("level monostable run mismatch");
  a_os_reset_armed: assert property (is_os && vnt == `PTMC_V5 && armed_q && enable_q && fall_on |=> timer_count_q == '0)
    else $error("one-shot falling reset missed");

  c_oneshot_done: cover property (stop_clear_en && is_os);
  c_mono_restart: cover property (ms_edge_mode && match ##[1:20] armed_q);
  c_free_edge_reset: cover property (is_free && ext_reset && timer_count_q != '0);
  c_level_release: cover property (is_free && vnt == `PTMC_V7 && lvl ##1 !lvl ##1 run);

endmodule : ptmc_timer

`default_nettype wire

// >>> pkg/ptmc_defs.svh
// constants of the period timer mode control
`ifndef PTMC_DEFS_SVH
`define PTMC_DEFS_SVH

// ----------------------------------------
// mode field layout
// ----------------------------------------
`define PTMC_MODE_W 5
`define PTMC_CLS_HI 4
`define PTMC_CLS_LO 3
`define PTMC_VAR_HI 2
`define PTMC_VAR_LO 0

// ----------------------------------------
// variant codes
// ----------------------------------------
`define PTMC_V0 3'h0
`define PTMC_V1 3'h1
`define PTMC_V2 3'h2
`define PTMC_V3 3'h3
`define PTMC_V4 3'h4
`define PTMC_V5 3'h5
`define PTMC_V6 3'h6
`define PTMC_V7 3'h7

// ----------------------------------------
// counter reset value and width
// ----------------------------------------
`define PTMC_COUNT_RST 8'h00
`define PTMC_COUNT_W 8

`endif

// >>> pkg/ptmc_edge_if.sv
// trigger level and edge bundle between detector and mode control
`timescale 1ns/1ps
`default_nettype none

interface ptmc_edge_if;
  logic level;
  logic rise;
  logic fall;

  modport src (output level, output rise, output fall);
  modport snk (input level, input rise, input fall);
endinterface : ptmc_edge_if

`default_nettype wire

// >>> pkg/ptmc_pkg.sv
// types of the period timer mode control
`default_nettype none

package ptmc_pkg;

  // ----------------------------------------
  // mode classes
  // ----------------------------------------
  typedef enum logic [1:0] {
    PTMC_FREE = 2'h0,
    PTMC_ONESHOT = 2'h1,
    PTMC_MONO = 2'h2,
    PTMC_RSVD = 2'h3
  } ptmc_class_type;

  typedef logic [2:0] ptmc_variant_type;

endpackage : ptmc_pkg

`default_nettype wire

// >>> verification/period_timer_mode_control_tb_top.sv
// scenario testbench of the period timer mode control
`timescale 1ns/1ps
`default_nettype none

module period_timer_mode_control_tb_top;
  logic core_clk, rst_n, enable_set, enable_clear, debug_mode;
  logic [4:0] mode;
  logic [7:0] timer_period, timer_count_q;
  logic ext_trigger_signal, enable_q, running_q, period_match_q, scaler_clear_q, mode_reserved_q;
  int n_fail, checks, v;
  logic [4:0] rsvd [4] = '{5'h18, 5'h1f, 5'h10, 5'h14};

  ptmc_trig_src ptmc_trig_src_i (.core_clk(core_clk), .ext_trigger_signal(ext_trigger_signal));

  ptmc_timer ptmc_timer_i (.core_clk(core_clk), .rst_n(rst_n), .mode(mode), .timer_period(timer_period),
    .enable_set(enable_set), .enable_clear(enable_clear), .ext_trigger_signal(ext_trigger_signal),
    .debug_mode(debug_mode), .timer_count_q(timer_count_q), .enable_q(enable_q), .running_q(running_q),
    .period_match_q(period_match_q), .scaler_clear_q(scaler_clear_q), .mode_reserved_q(mode_reserved_q));

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task pls(input bit clr);
    if (clr) enable_clear = 1'b1;
    else enable_set = 1'b1;
    cyc(1);
    enable_set = 1'b0;
    enable_clear = 1'b0;
  endtask : pls

  // fresh reset per scenario keeps the trigger's captured level at 0
  task start(input logic [4:0] m, input logic [7:0] p);
    rst_n = 1'b0;
    mode = m;
    timer_period = p;
    debug_mode = 1'b0;
    ptmc_trig_src_i.drive(1'b0);
    cyc(4);
    rst_n = 1'b1;
    pls(1'b0);
  endtask : start

  task results;
    if (n_fail == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task sc_free_sw;
    start(5'h00, 8'h02);
    cyc(2);
    chk(timer_count_q, 8'h02);
    cyc(1);
    chk(timer_count_q, 8'h00);
    chk({7'h0, period_match_q}, 8'h01);
    cyc(1);
    chk(timer_count_q, 8'h01);
  endtask : sc_free_sw

  task sc_gate;
    start(5'h01, 8'hff);
    cyc(4);
    chk(timer_count_q, 8'h00);
    ptmc_trig_src_i.drive(1'b1);
    cyc(4);
    chk(timer_count_q, 8'h03);
    ptmc_trig_src_i.drive(1'b0);
    cyc(2);
    v = timer_count_q;
    cyc(3);
    chk(timer_count_q, 8'(v));
  endtask : sc_gate

  task sc_edge_reset;
    start(5'h04, 8'hff);
    cyc(10);
    chk(timer_count_q, 8'h0a);
    ptmc_trig_src_i.drive(1'b1);
    cyc(1);
    chk(timer_count_q, 8'h00);
    chk({7'h0, scaler_clear_q}, 8'h01);
    ptmc_trig_src_i.drive(1'b0);
    cyc(1);
    chk({7'h0, scaler_clear_q}, 8'h00);
    debug_mode = 1'b1;
    ptmc_trig_src_i.drive(1'b1);
    cyc(1);
    v = timer_count_q;
    cyc(1);
    chk(timer_count_q, 8'(v + 1));
  endtask : sc_edge_reset

  task sc_oneshot_sw;
    start(5'h08, 8'h03);
    cyc(1);
    pls(1'b1);
    cyc(1);
    v = timer_count_q;
    cyc(3);
    chk(timer_count_q, 8'(v));
    pls(1'b0);
    cyc(3 - v);
    chk(timer_count_q, 8'h03);
    cyc(1);
    chk({enable_q, period_match_q, timer_count_q[5:0]}, 8'h40);
    cyc(2);
    chk(timer_count_q, 8'h00);
  endtask : sc_oneshot_sw

  task sc_oneshot_edge;
    start(5'h09, 8'h02);
    cyc(4);
    chk({enable_q, timer_count_q[6:0]}, 8'h80);
    ptmc_trig_src_i.drive(1'b1);
    cyc(3);
    chk(timer_count_q, 8'h02);
    cyc(1);
    chk({enable_q, timer_count_q[6:0]}, 8'h00);
  endtask : sc_oneshot_edge

  task sc_mono;
    start(5'h11, 8'h01);
    ptmc_trig_src_i.drive(1'b1);
    cyc(2);
    chk(timer_count_q, 8'h01);
    cyc(1);
    chk({enable_q, period_match_q, timer_count_q[5:0]}, 8'hc0);
    cyc(2);
    chk(timer_count_q, 8'h00);
    ptmc_trig_src_i.drive(1'b0);
    ptmc_trig_src_i.drive(1'b1);
    cyc(2);
    chk(timer_count_q, 8'h01);
  endtask : sc_mono

  task sc_level_free;
    start(5'h06, 8'hff);
    cyc(3);
    chk({7'h0, scaler_clear_q}, 8'h01);
    ptmc_trig_src_i.drive(1'b1);
    cyc(3);
    chk(timer_count_q, 8'h02);
    chk({7'h0, running_q}, 8'h01);
  endtask : sc_level_free

  task sc_oneshot_hl;
    start(5'h0c, 8'hff);
    ptmc_trig_src_i.drive(1'b1);
    cyc(4);
    chk(timer_count_q, 8'h03);
    ptmc_trig_src_i.drive(1'b0);
    ptmc_trig_src_i.drive(1'b1);
    cyc(1);
    chk(timer_count_q, 8'h00);
    chk({7'h0, scaler_clear_q}, 8'h01);
    cyc(2);
    chk({enable_q, timer_count_q[6:0]}, 8'h82);
  endtask : sc_oneshot_hl

  task sc_mono_level;
    start(5'h16, 8'h03);
    ptmc_trig_src_i.drive(1'b1);
    cyc(4);
    chk(timer_count_q, 8'h03);
    cyc(1);
    chk({enable_q, period_match_q, timer_count_q[5:0]}, 8'h40);
  endtask : sc_mono_level

  task sc_any_edge;
    start(5'h13, 8'h01);
    ptmc_trig_src_i.drive(1'b1);
    cyc(3);
    chk({enable_q, period_match_q, timer_count_q[5:0]}, 8'hc0);
    ptmc_trig_src_i.drive(1'b0);
    cyc(2);
    chk(timer_count_q, 8'h01);
  endtask : sc_any_edge

  task sc_reserved;
    foreach (rsvd[i])
    begin
      start(rsvd[i], 8'h02);
      cyc(4);
      chk({mode_reserved_q, timer_count_q[6:0]}, 8'h80);
    end
  endtask : sc_reserved

  initial
  begin
    #200000;
    n_fail++;
    results();
  end

  initial
  begin
    n_fail = 0;
    checks = 0;
    {rst_n, enable_set, enable_clear, debug_mode} = 4'h0;
    mode = 5'h00;
    timer_period = 8'h00;
    cyc(1);
    sc_free_sw();
    sc_gate();
    sc_edge_reset();
    sc_oneshot_sw();
    sc_oneshot_edge();
    sc_mono();
    sc_level_free();
    sc_oneshot_hl();
    sc_mono_level();
    sc_any_edge();
    sc_reserved();
    results();
  end
endmodule : period_timer_mode_control_tb_top

`default_nettype wire

// >>> verification/ptmc_trig_src.sv
// trigger source model driving the external trigger of the timer
`timescale 1ns/1ps
`default_nettype none

module ptmc_trig_src
(
  input wire logic core_clk,
  output logic ext_trigger_signal
);
  int edges = 0;
  int last = -6;

  // ----------------------------------------
  // spacing of changes
  // ----------------------------------------
  always @(posedge core_clk)
    edges <= edges + 1;

  // waits out the spacing before any change, so no caller can break it
  task drive(input logic v);
    repeat (6)
      if (edges - last < 6) @(negedge core_clk);
    ext_trigger_signal = v;
    last = edges;
  endtask : drive
endmodule : ptmc_trig_src

`default_nettype wire
